// >>> csm_speed_ctl.sv
// Speed-mode control: command port latch, cache gate, waits, tone
// How it works
// - The processor clock passes through untouched in both modes.
// - Slowed mode disables the cache and stretches each bus cycle.
// - A byte write of the slow code to port 64h enters slowed mode.
// - A byte write of the fast code to port 64h returns to full speed.
// - Warm and software resets leave the mode latch as it is.
// - Power-on reset reloads the mode from the setup selection.
// - Keyboard-initiated changes sound a low or high tone.
`timescale 1ns/10ps
`default_nettype none
module csm_speed_ctl
#(
	parameter logic [3:0] WAIT_STATES = csm_pkg::WAIT_DEFAULT
)
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        por_n,
	input  wire logic        setup_slow,
	input  wire logic        io_wr,
	input  wire logic [15:0] io_addr,
	input  wire logic [7:0]  io_data,
	input  wire logic        kbd_src,
	input  wire logic        cyc_start,
	output logic             cyc_ready,
	output logic             cpu_clk,
	output logic             cache_en,
	output logic             slow_mode,
	output logic             cmd_other,
	output logic [7:0]       cmd_other_data,
	output logic             spkr
);
	typedef enum logic [1:0]
	{
		CSM_QUIET = 2'b01,
		CSM_TONE  = 2'b10
	} csm_state_t;

	typedef struct packed
	{
		csm_state_t  st;
		logic        mode;
		logic        por_seen;
		logic        other;
		logic [7:0]  other_data;
		logic        tone_low;
		logic [3:0]  half;
		logic [11:0] len;
		logic        spk;
	} csm_core_t;

	csm_core_t s;
	csm_core_t next_s;
	logic      port_hit;
	logic      is_slow;
	logic      is_fast;
	logic      tone_go;

	// Exact stall length that a slowed bus cycle must see
	localparam int WAIT_HI = int'(WAIT_STATES) + 1;

	csm_wait_if wif();

	assign port_hit = io_wr && io_addr == csm_pkg::CMD_PORT_ADDR;
	assign is_slow  = port_hit && io_data == csm_pkg::CODE_SLOW;
	assign is_fast  = port_hit && io_data == csm_pkg::CODE_FAST;
	// A keyboard code during a tone restarts it from the top
	assign tone_go  = s.por_seen && kbd_src && (is_slow || is_fast);

	always_comb
	begin
		next_s       = s;
		next_s.other = 1'b0;
		// Setup strap taken on the first clock after power-on release
		if (!s.por_seen)
		begin
			next_s.por_seen = 1'b1;
			next_s.mode     = setup_slow;
		end
		else if (is_slow)
			next_s.mode = csm_pkg::MODE_SLOW;
		else if (is_fast)
			next_s.mode = csm_pkg::MODE_FAST;
		else if (port_hit)
		begin
			next_s.other      = 1'b1;
			next_s.other_data = io_data;
		end
		if (tone_go)
		begin
			next_s.st       = CSM_TONE;
			next_s.tone_low = is_slow;
			next_s.len      = csm_pkg::TONE_LEN;
			next_s.half     = 4'h0;
		end
		else
		begin
			case (s.st)
				CSM_QUIET:
					next_s.spk = 1'b0;
				CSM_TONE:
				begin
					next_s.len = s.len - 12'h001;
					if (s.half == (s.tone_low ? csm_pkg::TONE_LOW_HALF
						: csm_pkg::TONE_HIGH_HALF))
					begin
						next_s.half = 4'h0;
						next_s.spk  = !s.spk;
					end
					else
						next_s.half = s.half + 4'h1;
					if (s.len == 12'h000)
					begin
						next_s.st  = CSM_QUIET;
						next_s.spk = 1'b0;
					end
				end
				default:
					next_s.st = CSM_QUIET;
			endcase
		end
	end

	// Only power-on clears state; warm resets never reach this flop
	always_ff @(posedge mclk or negedge por_n)
	begin
		if (!por_n)
		begin
			s          <= '0;
			s.st       <= CSM_QUIET;
		end
		else
			s <= next_s;
	end

	assign wif.slow  = s.mode;
	assign wif.waits = WAIT_STATES;

	csm_wait_gen u_wait
	(
		.mclk      (mclk),
		.reset_n   (reset_n),
		.wif       (wif),
		.cyc_start (cyc_start),
		.cyc_ready (cyc_ready)
	);

	assign cpu_clk        = mclk;
	assign cache_en       = !s.mode;
	assign slow_mode      = s.mode;
	assign cmd_other      = s.other;
	assign cmd_other_data = s.other_data;
	assign spkr           = s.spk;

	a_slow_entry: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.por_seen && is_slow |=> slow_mode && !cache_en)
		else $error("slow code did not enter slowed mode");
	a_fast_entry: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.por_seen && is_fast |=> !slow_mode && cache_en)
		else $error("fast code did not restore full speed");
	a_other_keep: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.por_seen && !is_slow && !is_fast |=> $stable(slow_mode))
		else $error("mode changed without a speed code");
	a_other_pass: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.por_seen && port_hit && !is_slow && !is_fast
		|=> cmd_other && cmd_other_data == $past(io_data))
		else $error("other command not passed on");
	a_cache_gate: assert property (@(posedge mclk)
		disable iff (!por_n)
		cache_en == !slow_mode)
		else $error("cache enable disagrees with mode");
	a_wait_stall: assert property (@(posedge mclk)
		disable iff (!reset_n)
		cyc_start && slow_mode && WAIT_STATES != 4'h0 |-> !cyc_ready)
		else $error("slowed cycle not stretched");
	a_wait_done: assert property (@(posedge mclk)
		disable iff (!reset_n)
		cyc_start && slow_mode && !u_wait.s.busy
		|-> ##[WAIT_HI:WAIT_HI] cyc_ready)
		else $error("slowed cycle not released in time");
	a_fast_nowait: assert property (@(posedge mclk)
		disable iff (!reset_n)
		cyc_start && !slow_mode && !u_wait.s.busy |-> cyc_ready)
		else $error("full-speed cycle stretched");
	a_por_load: assert property (@(posedge mclk)
		disable iff (!por_n)
		!s.por_seen |=> slow_mode == $past(setup_slow))
		else $error("setup mode not loaded at power-on");
	a_warm_hold: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.por_seen && !reset_n && !is_slow && !is_fast
		|=> $stable(slow_mode))
		else $error("warm reset changed the mode");
	a_kbd_tone: assert property (@(posedge mclk)
		disable iff (!por_n)
		tone_go && is_slow |=> s.st == CSM_TONE && s.tone_low
		&& s.len == csm_pkg::TONE_LEN)
		else $error("no low tone on keyboard slow switch");
	a_kbd_high: assert property (@(posedge mclk)
		disable iff (!por_n)
		tone_go && is_fast |=> s.st == CSM_TONE && !s.tone_low
		&& s.len == csm_pkg::TONE_LEN)
		else $error("no high tone on keyboard fast switch");
	a_tone_hold: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.st == CSM_TONE && s.len != 12'h000 |=> s.st == CSM_TONE)
		else $error("tone ended before its length ran out");
	a_tone_end: assert property (@(posedge mclk)
		disable iff (!por_n)
		s.st == CSM_TONE && s.len == 12'h000 && !tone_go
		|=> s.st == CSM_QUIET && !spkr)
		else $error("tone kept sounding past its length");

	c_to_slow: cover property (@(posedge mclk) disable iff (!por_n)
		s.por_seen && is_slow);
	c_to_fast: cover property (@(posedge mclk) disable iff (!por_n)
		slow_mode ##1 is_fast);
	c_kbd_tone: cover property (@(posedge mclk) disable iff (!por_n)
		s.st == CSM_TONE ##[1:8] spkr);
	c_tone_high: cover property (@(posedge mclk) disable iff (!por_n)
		tone_go && is_fast);
	c_warm_keep: cover property (@(posedge mclk) disable iff (!por_n)
		slow_mode && !reset_n);
endmodule // csm_speed_ctl
`default_nettype wire

// >>> csm_pkg.sv
// Shared constants for the speed-mode control block
package csm_pkg;
	localparam logic [15:0] CMD_PORT_ADDR = 16'h0064;
	localparam logic [7:0]  CODE_SLOW     = 8'hea;
	localparam logic [7:0]  CODE_FAST     = 8'he5;
	localparam int          CLK_MHZ       = 25;
	localparam int          SLOW_MHZ      = 8;
	// Wait count per slowed bus cycle; ready is held back this many cycles plus one
	localparam logic [3:0]  WAIT_DEFAULT  = 4'h2;
	localparam logic        MODE_FAST     = 1'b0;
	localparam logic        MODE_SLOW     = 1'b1;
	localparam logic [3:0]  TONE_LOW_HALF = 4'hf;
	localparam logic [3:0]  TONE_HIGH_HALF = 4'h5;
	localparam logic [11:0] TONE_LEN      = 12'h0fff;
endpackage

// >>> csm_wait_if.sv
// Handshake between the mode core and the wait-state stretcher
`timescale 1ns/10ps
`default_nettype none
interface csm_wait_if;
	logic       slow;
	logic [3:0] waits;
	modport core (output slow, output waits);
	modport gen  (input slow, input waits);
endinterface
`default_nettype wire

// >>> csm_wait_gen.sv
// Wait-state stretcher that holds off bus ready in slowed mode
`timescale 1ns/10ps
`default_nettype none
module csm_wait_gen
(
	input  wire logic mclk,
	input  wire logic reset_n,
	csm_wait_if.gen   wif,
	input  wire logic cyc_start,
	output logic      cyc_ready
);
	typedef struct packed
	{
		logic [3:0] cnt;
		logic       busy;
	} csm_wst_t;
	csm_wst_t s;
	csm_wst_t next_s;

	always_comb
	begin
		next_s = s;
		if (cyc_start && wif.slow && wif.waits != 4'h0)
		begin
			next_s.busy = 1'b1;
			next_s.cnt  = wif.waits;
		end
		else if (s.busy)
		begin
			next_s.cnt  = s.cnt - 4'h1;
			next_s.busy = (s.cnt != 4'h1);
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else
			s <= next_s;
	end

	// Full speed starts no stall but waits out a count left from slowed mode; slowed mode stalls each bus cycle when waits is nonzero
	assign cyc_ready = !s.busy && !(cyc_start && wif.slow
		&& wif.waits != 4'h0);
endmodule // csm_wait_gen
`default_nettype wire

// >>> csm_host_model.sv
// Host model that writes bytes to the speed command port
`timescale 1ns/10ps
`default_nettype none
module csm_host_model
(
	input  wire logic   mclk,
	output logic        io_wr,
	output logic [15:0] io_addr,
	output logic [7:0]  io_data,
	output logic        kbd_src
);
	initial
	begin
		io_wr = 1'b0;
		io_addr = 16'h0000;
		io_data = 8'h00;
		kbd_src = 1'b0;
	end
	task automatic send(input logic [15:0] a, input logic [7:0] d,
		input logic kb);
		@(posedge mclk);
		#1;
		io_wr = 1'b1;
		io_addr = a;
		io_data = d;
		kbd_src = kb;
		@(posedge mclk);
		#1;
		io_wr = 1'b0;
		kbd_src = 1'b0;
		// Released lines must not keep the last value
		io_addr = ~a;
		io_data = ~d;
	endtask
	// Keypad digit 1 asks for slowed mode and 2 for full speed
	task automatic keypad(input logic [3:0] digit);
		if (digit == 4'h1)
			send(csm_pkg::CMD_PORT_ADDR, csm_pkg::CODE_SLOW,
				1'b1);
		else if (digit == 4'h2)
			send(csm_pkg::CMD_PORT_ADDR, csm_pkg::CODE_FAST,
				1'b1);
	endtask
endmodule // csm_host_model
`default_nettype wire

// >>> csm_speed_ctl_tb_top.sv
// Self-checking bench for the speed-mode control block
`timescale 1ns/10ps
`default_nettype none
module csm_speed_ctl_tb_top;
	localparam logic [3:0] WS = 4'h2;
	logic        mclk, reset_n, por_n, setup_slow, cyc_start, io_wr;
	logic        kbd_src, cyc_ready, cpu_clk, cache_en, slow_mode;
	logic        cmd_other, spkr;
	logic [15:0] io_addr;
	logic [7:0]  io_data, cmd_other_data;
	int          err_total, checks_done, cyc, n;
	csm_speed_ctl #(.WAIT_STATES(WS)) i_csm_speed_ctl (.mclk, .reset_n,
		.por_n, .setup_slow, .io_wr, .io_addr, .io_data, .kbd_src,
		.cyc_start, .cyc_ready, .cpu_clk, .cache_en, .slow_mode,
		.cmd_other, .cmd_other_data, .spkr);
	csm_host_model i_csm_host_model (.mclk, .io_wr, .io_addr, .io_data,
		.kbd_src);
	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Two tones of 4096 cycles dominate the run
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, s);
		checks_done++;
		if (s !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] d);
		i_csm_host_model.send(csm_pkg::CMD_PORT_ADDR, d, 1'b0);
	endtask
	task automatic t_por(input logic s);
		por_n = 1'b0;
		reset_n = 1'b0;
		setup_slow = s;
		repeat (5) @(posedge mclk);
		#1;
		por_n = 1'b1;
		reset_n = 1'b1;
		@(posedge mclk);
		#1;
		chk("mode", 8'(s), 8'(slow_mode));
		chk("cache", 8'(!s), 8'(cache_en));
		$display("por test done");
	endtask
	task automatic t_wait(input logic sl);
		@(posedge mclk);
		#1;
		cyc_start = 1'b1;
		for (int i = 0; i <= WS + 1; i++)
		begin
			#1;
			chk("ready", 8'(!sl || i == WS + 1),
				8'(cyc_ready));
			chk("cpu clk", 8'h01, 8'(cpu_clk));
			@(posedge mclk);
			#1;
			cyc_start = 1'b0;
		end
		@(negedge mclk);
		#1;
		chk("cpu clk", 8'h00, 8'(cpu_clk));
		$display("wait test done");
	endtask
	task automatic t_cmd();
		wr(csm_pkg::CODE_SLOW);
		chk("mode", 8'h01, 8'(slow_mode));
		chk("cache", 8'h00, 8'(cache_en));
		i_csm_host_model.send(16'h0065, csm_pkg::CODE_FAST, 1'b0);
		chk("mode", 8'h01, 8'(slow_mode));
		wr(8'h55);
		chk("other", 8'h01, 8'(cmd_other));
		chk("data", 8'h55, cmd_other_data);
		chk("mode", 8'h01, 8'(slow_mode));
		wr(csm_pkg::CODE_FAST);
		chk("mode", 8'h00, 8'(slow_mode));
		chk("cache", 8'h01, 8'(cache_en));
		chk("other", 8'h00, 8'(cmd_other));
		chk("spkr", 8'h00, 8'(spkr));
		$display("command test done");
	endtask
	task automatic t_warm();
		wr(csm_pkg::CODE_FAST);
		chk("mode", 8'h00, 8'(slow_mode));
		wr(csm_pkg::CODE_SLOW);
		chk("mode", 8'h01, 8'(slow_mode));
		reset_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		chk("mode", 8'h01, 8'(slow_mode));
		t_wait(1'b1);
		$display("warm test done");
	endtask
	task automatic t_tone(input logic [3:0] key, input int half);
		i_csm_host_model.keypad(key);
		chk("mode", 8'(key == 4'h1), 8'(slow_mode));
		n = 0;
		while (spkr !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		n = 0;
		while (spkr === 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("half", 8'(half), 8'(n));
		repeat (4200) @(posedge mclk);
		#1;
		chk("spkr", 8'h00, 8'(spkr));
		$display("tone test done");
	endtask
	initial
	begin
		cyc_start = 1'b0;
		t_por(1'b0);
		t_wait(1'b0);
		t_cmd();
		t_por(1'b1);
		t_warm();
		t_tone(4'h2, 6);
		t_tone(4'h1, 16);
		give_verdict();
	end
endmodule // csm_speed_ctl_tb_top
`default_nettype wire
